// >>> inc/dbs_pkg.sv
// Shared constants and types for the burst-of-two DDR SRAM link
package dbs_pkg;
    // Link geometry defaults
    localparam int DATA_W     = 18;
    localparam int LANE_W     = 9;
    localparam int ADDR_W     = 8;
    localparam int BEATS      = 2;
    // Controller makes the link clock: half period in system cycles
    localparam int K_HALF     = 8;
    // Impedance evaluation interval, in nanoseconds and in cycles
    localparam int SYS_PERIOD_NS   = 4;
    localparam int ZQ_INTERVAL_NS  = 4096;
    localparam int ZQ_EVAL_CYCLES  = ZQ_INTERVAL_NS / SYS_PERIOD_NS;
    localparam int ZCODE_W         = 6;
    localparam logic [5:0] ZCODE_RST = 6'h20;
    // Controller register offsets (byte addresses, one word each)
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_ADDR   = 8'h04;
    localparam logic [7:0] OFF_WDATA0 = 8'h08;
    localparam logic [7:0] OFF_WDATA1 = 8'h0c;
    localparam logic [7:0] OFF_MASK   = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_RDATA0 = 8'h18;
    localparam logic [7:0] OFF_RDATA1 = 8'h1c;
    // Field positions
    localparam int CTRL_GO    = 0;
    localparam int CTRL_READ  = 1;
    localparam int CTRL_TERM  = 2;
    localparam int STAT_BUSY  = 0;
    localparam int STAT_DONE  = 2;
    localparam int MASK_B1    = 16;
    // Operation carried down the command pipeline
    typedef enum logic [1:0] {
        OP_IDLE  = 2'b00,
        OP_READ  = 2'b01,
        OP_WRITE = 2'b10
    } dbs_op_t;
    // Controller sequencer states
    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_RUN  = 2'b01,
        CS_CAPT = 2'b10
    } dbs_cstate_t;
endpackage

// >>> inc/dbs_link_if.sv
// Pin-level link between the SRAM controller and the SRAM
`timescale 1ns/1ps
interface dbs_link_if #(
    parameter int DW = dbs_pkg::DATA_W,
    parameter int MW = dbs_pkg::DATA_W / dbs_pkg::LANE_W,
    parameter int AW = dbs_pkg::ADDR_W
);
    logic          k;
    logic          k_n;
    logic          load_strobe_n;
    logic          read_write_sel;
    logic [AW-1:0] addr;
    logic [MW-1:0] lane_mask_n;
    logic          termination_select;
    logic [DW-1:0] dq_ctl;
    logic          dq_ctl_oe;
    logic          ctl_term_on;
    logic [DW-1:0] dq_mem;
    logic          dq_mem_oe;
    logic          mem_term_on;
    logic          read_valid_flag;
    logic [DW-1:0] dq;
    // Shared data wire; an undriven bus reads as zero here
    assign dq = dq_mem_oe ? dq_mem : (dq_ctl_oe ? dq_ctl : '0);
    modport mem (
        input  k, k_n, load_strobe_n, read_write_sel, addr, lane_mask_n,
        input  termination_select, dq,
        output dq_mem, dq_mem_oe, mem_term_on, read_valid_flag
    );
    modport ctl (
        output k, k_n, load_strobe_n, read_write_sel, addr, lane_mask_n,
        output termination_select, dq_ctl, dq_ctl_oe, ctl_term_on,
        input  dq, read_valid_flag
    );
endinterface

// >>> hdl/dbs_sram_mem.sv
// SRAM end of the link: command pipeline, array, drivers, impedance
//
// Behaviour
// R1 - Each command moves exactly two data beats
// R2 - Controller may issue one command per cycle
// R3 - Deselect after read lets read finish
// R4 - Load strobe high ignores command, deselects
// R5 - Commands sampled on true-clock rising edge
// R6 - Strobe low, select high means read
// R7 - Write beats at next true, inverted edges
// R8 - High mask bit keeps that lane unchanged
// R9 - Each lane maskable in each beat
// R10 - Nibble lanes on the narrow version
// R11 - Cycle counter periodically triggers impedance evaluation
// R12 - Each evaluation moves codes one step
// R13 - Termination select high enables termination
// R14 - Controller always drives masks and clocks
// R15 - Data termination off around read drive
// R16 - Controller drives idle/write, releases on read
// R17 - Controller keeps unterminated gaps short
// R18 - Idle or write: drivers off one cycle
// R19 - Termination sets level while drivers off
// R20 - Read beats at 2.5 and 3 cycles
// R21 - All lanes masked aborts the write
`timescale 1ns/1ps
module dbs_sram_mem #(
    parameter int DW       = dbs_pkg::DATA_W,
    parameter int LANE_W   = dbs_pkg::LANE_W,
    parameter int AW       = dbs_pkg::ADDR_W,
    parameter int ZQ_EVAL  = dbs_pkg::ZQ_EVAL_CYCLES
) (
    input  wire logic                        clk_sys_in,
    input  wire logic                        resetn_in,
    dbs_link_if.mem                          link,
    input  wire logic [dbs_pkg::ZCODE_W-1:0] impedance_reference_resistor_in,
    output logic      [dbs_pkg::ZCODE_W-1:0] drive_code_out,
    output logic      [dbs_pkg::ZCODE_W-1:0] term_code_out
);
    localparam int MW = DW / LANE_W;
    localparam int SW = 5 + AW + MW + DW;
    localparam int ZW = dbs_pkg::ZCODE_W;

    // Refuse geometries the lane logic cannot serve
    if (DW % LANE_W != 0 || MW < 1 || AW < 1 || ZQ_EVAL < 2) begin : g_bad
        $error("dbs_sram_mem: unsupported parameters");
    end

    // Two-stage synchroniser for every link input
    logic [SW-1:0] sy1_r;
    logic [SW-1:0] sy2_r;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sy1_r <= '0;
            sy2_r <= '0;
        end else begin
            sy1_r <= {link.k, link.k_n, link.load_strobe_n, link.read_write_sel,
                      link.termination_select, link.addr, link.lane_mask_n, link.dq};
            sy2_r <= sy1_r;
        end
    end

    logic          k_s;
    logic          kn_s;
    logic          ld_n_s;
    logic          rw_s;
    logic          odt_s;
    logic [AW-1:0] addr_s;
    logic [MW-1:0] mask_n_s;
    logic [DW-1:0] dq_s;
    assign {k_s, kn_s, ld_n_s, rw_s, odt_s, addr_s, mask_n_s, dq_s} = sy2_r;

    // Edge detection on the synchronised clocks
    logic k_d_r;
    logic kn_d_r;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            k_d_r  <= 1'b0;
            kn_d_r <= 1'b0;
        end else begin
            k_d_r  <= k_s;
            kn_d_r <= kn_s;
        end
    end
    logic k_rise;
    logic kn_rise;
    assign k_rise  = k_s & ~k_d_r;
    assign kn_rise = kn_s & ~kn_d_r;

    // Decode of the sampled command
    dbs_pkg::dbs_op_t op_new;
    always_comb begin
        // R4 ignore when strobe high
        if (ld_n_s)
            op_new = dbs_pkg::OP_IDLE;
        // R6 read decode
        else if (rw_s)
            op_new = dbs_pkg::OP_READ;
        else
            op_new = dbs_pkg::OP_WRITE;
    end

    // Command pipeline, one stage per true-clock cycle; deselects
    // travel the same path as reads so a read never gets cut short
    dbs_pkg::dbs_op_t op_r [1:3];
    logic [AW-1:0]    ad_r [1:3];
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 1; i <= 3; i++) begin
                op_r[i] <= dbs_pkg::OP_IDLE;
                ad_r[i] <= '0;
            end
        // R5 sample on true edge
        end else if (k_rise) begin
            // R2 new command every cycle
            op_r[1] <= op_new;
            ad_r[1] <= addr_s;
            // R3 deselect pipelined like read
            op_r[2] <= op_r[1];
            ad_r[2] <= ad_r[1];
            op_r[3] <= op_r[2];
            ad_r[3] <= ad_r[2];
        end
    end

    // Storage: two words per address, one per beat
    logic [DW-1:0] mem_r [0:2**AW-1][0:dbs_pkg::BEATS-1];

    // Write beat selection: beat 0 on the true edge, beat 1 on the inverted
    logic          wr_b0;
    logic          wr_b1;
    logic          wr_go;
    logic          wr_beat;
    logic [AW-1:0] wr_addr;
    // R7 late write beat timing
    assign wr_b0   = k_rise && op_r[1] == dbs_pkg::OP_WRITE;
    assign wr_b1   = kn_rise && op_r[2] == dbs_pkg::OP_WRITE;
    assign wr_beat = wr_b1;
    assign wr_addr = wr_b1 ? ad_r[2] : ad_r[1];

    // Per-lane merge of new data into the stored word
    logic [DW-1:0] lane_bits;
    for (genvar g = 0; g < MW; g++) begin : g_lane
        // R8 high mask keeps lane
        // R10 lane width follows LANE_W
        assign lane_bits[g*LANE_W +: LANE_W] = {LANE_W{~mask_n_s[g]}};
    end
    logic [DW-1:0] merged;
    assign merged = (mem_r[wr_addr][wr_beat] & ~lane_bits) | (dq_s & lane_bits);
    // R21 no lane enabled, no store
    assign wr_go = (wr_b0 || wr_b1) && (lane_bits != '0);

    // Array write; the memory itself has no reset
    always_ff @(posedge clk_sys_in) begin
        // R9 each beat masked independently
        if (wr_go)
            mem_r[wr_addr][wr_beat] <= merged;
    end

    // Output drivers and valid flag
    logic [DW-1:0] q_r;
    logic          q_oe_r;
    logic          qv_r;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q_r    <= '0;
            q_oe_r <= 1'b0;
            qv_r   <= 1'b0;
        end else if (kn_rise) begin
            // R20 first beat at 2.5 cycles
            if (op_r[3] == dbs_pkg::OP_READ) begin
                q_r    <= mem_r[ad_r[3]][0];
                q_oe_r <= 1'b1;
                qv_r   <= 1'b1;
            // R18 drivers off one cycle
            end else begin
                q_oe_r <= 1'b0;
                qv_r   <= 1'b0;
            end
        end else if (k_rise) begin
            // R1 second beat completes burst
            if (op_r[3] == dbs_pkg::OP_READ) begin
                q_r <= mem_r[ad_r[3]][1];
            end else begin
                q_oe_r <= 1'b0;
                qv_r   <= 1'b0;
            end
        end
    end
    assign link.dq_mem          = q_r;
    assign link.dq_mem_oe       = q_oe_r;
    assign link.read_valid_flag = qv_r;

    // Data-line termination: dropped half a cycle before read drive starts,
    // restored half a cycle after it ends; both points fall on true edges
    logic rd_window_r;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in)
            rd_window_r <= 1'b0;
        // R15 termination window around reads
        else if (k_rise)
            rd_window_r <= (op_r[2] == dbs_pkg::OP_READ) || (op_r[3] == dbs_pkg::OP_READ);
    end
    logic term_r;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in)
            term_r <= 1'b0;
        // R13 select enables termination
        // R19 termination holds the idle level
        else
            term_r <= odt_s & ~rd_window_r;
    end
    assign link.mem_term_on = term_r;

    // Impedance evaluation timer
    logic [$clog2(ZQ_EVAL)-1:0] zq_cnt_r;
    logic                       zq_trig;
    assign zq_trig = (zq_cnt_r == ($clog2(ZQ_EVAL))'(ZQ_EVAL - 1));
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in)
            zq_cnt_r <= '0;
        // R11 count, trigger, restart
        else if (zq_trig)
            zq_cnt_r <= '0;
        else
            zq_cnt_r <= zq_cnt_r + 1'b1;
    end

    // Reference code is a static strap but still crosses into this domain
    logic [ZW-1:0] zref1_r;
    logic [ZW-1:0] zref2_r;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            zref1_r <= dbs_pkg::ZCODE_RST;
            zref2_r <= dbs_pkg::ZCODE_RST;
        end else begin
            zref1_r <= impedance_reference_resistor_in;
            zref2_r <= zref1_r;
        end
    end

    // Codes walk one binary step per evaluation so drive never jumps
    logic [ZW-1:0] drv_r;
    logic [ZW-1:0] trm_r;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            drv_r <= dbs_pkg::ZCODE_RST;
            trm_r <= dbs_pkg::ZCODE_RST;
        // R12 one step per evaluation
        end else if (zq_trig) begin
            if (drv_r < zref2_r)
                drv_r <= drv_r + 1'b1;
            else if (drv_r > zref2_r)
                drv_r <= drv_r - 1'b1;
            if (trm_r < zref2_r)
                trm_r <= trm_r + 1'b1;
            else if (trm_r > zref2_r)
                trm_r <= trm_r - 1'b1;
        end
    end
    assign drive_code_out = drv_r;
    assign term_code_out  = trm_r;
endmodule

// >>> hdl/dbs_sram_ctl.sv
// Controller end of the link: APB registers, clock divider, sequencer
`timescale 1ns/1ps
module dbs_sram_ctl #(
    parameter int DW     = dbs_pkg::DATA_W,
    parameter int LANE_W = dbs_pkg::LANE_W,
    parameter int AW     = dbs_pkg::ADDR_W,
    parameter int KH     = dbs_pkg::K_HALF
) (
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    dbs_link_if.ctl          link
);
    localparam int MW = DW / LANE_W;
    localparam int PW = $clog2(2 * KH);

    // Refuse geometries the registers or divider cannot serve
    if (DW % LANE_W != 0 || DW > 32 || MW > 16 || AW > 32 || KH < 4 || KH % 2 != 0)
    begin : g_bad
        $error("dbs_sram_ctl: unsupported parameters");
    end

    // Link clock divider; commands and data change mid-half so the
    // SRAM sees them settled on both sides of each clock edge
    logic [PW-1:0] ph_r;
    logic [PW-1:0] ph_nxt;
    logic          k_r;
    logic          mid;
    logic          mid_low;
    assign ph_nxt  = (ph_r == PW'(2 * KH - 1)) ? '0 : ph_r + 1'b1;
    assign mid     = (ph_nxt == PW'(KH / 2)) || mid_low;
    assign mid_low = (ph_nxt == PW'(KH + KH / 2));
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ph_r <= '0;
            k_r  <= 1'b0;
        end else begin
            ph_r <= ph_nxt;
            k_r  <= (ph_nxt < PW'(KH));
        end
    end
    // R14 clocks always driven
    assign link.k   = k_r;
    assign link.k_n = ~k_r;

    // Register state
    logic          go_r;
    logic          rd_r;
    logic          odt_r;
    logic          done_r;
    logic [AW-1:0] addr_r;
    logic [DW-1:0] wd0_r;
    logic [DW-1:0] wd1_r;
    logic [MW-1:0] m0_r;
    logic [MW-1:0] m1_r;
    logic [DW-1:0] rd0_r;
    logic [DW-1:0] rd1_r;
    dbs_pkg::dbs_cstate_t st_r;
    logic          busy;
    logic          fin;
    assign busy = go_r || (st_r != dbs_pkg::CS_IDLE);

    // APB decode; the slave never stretches an access
    logic wr_acc;
    logic mapped;
    assign wr_acc = psel_in && penable_in && pwrite_in;
    assign mapped = (paddr_in[1:0] == 2'b00) && (paddr_in <= dbs_pkg::OFF_RDATA1);
    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in && penable_in && !mapped;

    // Software writes; a start while busy is dropped
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            go_r   <= 1'b0;
            rd_r   <= 1'b0;
            odt_r  <= 1'b0;
            addr_r <= '0;
            wd0_r  <= '0;
            wd1_r  <= '0;
            m0_r   <= '1;
            m1_r   <= '1;
        end else begin
            if (st_r == dbs_pkg::CS_IDLE && go_r && mid_low)
                go_r <= 1'b0;
            if (wr_acc && !busy) begin
                case (paddr_in)
                    dbs_pkg::OFF_CTRL: begin
                        go_r  <= pwdata_in[dbs_pkg::CTRL_GO];
                        rd_r  <= pwdata_in[dbs_pkg::CTRL_READ];
                        odt_r <= pwdata_in[dbs_pkg::CTRL_TERM];
                    end
                    dbs_pkg::OFF_ADDR:   addr_r <= pwdata_in[AW-1:0];
                    dbs_pkg::OFF_WDATA0: wd0_r  <= pwdata_in[DW-1:0];
                    dbs_pkg::OFF_WDATA1: wd1_r  <= pwdata_in[DW-1:0];
                    dbs_pkg::OFF_MASK: begin
                        m0_r <= pwdata_in[MW-1:0];
                        m1_r <= pwdata_in[dbs_pkg::MASK_B1 +: MW];
                    end
                    default: ;
                endcase
            end
        end
    end

    // Done flag: completion sets it, a new start clears it
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in)
            done_r <= 1'b0;
        else if (fin)
            done_r <= 1'b1;
        else if (wr_acc && !busy && paddr_in == dbs_pkg::OFF_CTRL && pwdata_in[dbs_pkg::CTRL_GO])
            done_r <= 1'b0;
    end

    // Read data captured in the setup cycle, held through the access
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in)
            prdata_out <= '0;
        else if (psel_in && !penable_in) begin
            case (paddr_in)
                dbs_pkg::OFF_CTRL:   prdata_out <= 32'({odt_r, rd_r, go_r});
                dbs_pkg::OFF_ADDR:   prdata_out <= 32'(addr_r);
                dbs_pkg::OFF_WDATA0: prdata_out <= 32'(wd0_r);
                dbs_pkg::OFF_WDATA1: prdata_out <= 32'(wd1_r);
                dbs_pkg::OFF_MASK:   prdata_out <= 32'(m0_r) | (32'(m1_r) << dbs_pkg::MASK_B1);
                dbs_pkg::OFF_STATUS: prdata_out <= 32'({done_r, 1'b0, busy});
                dbs_pkg::OFF_RDATA0: prdata_out <= 32'(rd0_r);
                dbs_pkg::OFF_RDATA1: prdata_out <= 32'(rd1_r);
                default:             prdata_out <= '0;
            endcase
        end
    end

    // Returning read data and flag cross in through two flip-flops
    logic [DW:0] rs1_r;
    logic [DW:0] rs2_r;
    logic        qv_d_r;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rs1_r  <= '0;
            rs2_r  <= '0;
            qv_d_r <= 1'b0;
        end else begin
            rs1_r  <= {link.read_valid_flag, link.dq};
            rs2_r  <= rs1_r;
            qv_d_r <= rs2_r[DW];
        end
    end

    // Sequencer: half-cycle count from the cycle the command is shown
    logic [2:0]    hc_r;
    logic [PW:0]   cap_r;
    logic          ld_n_r;
    logic          rw_r;
    logic [AW-1:0] a_r;
    logic [DW-1:0] dq_r;
    logic          oe_r;
    logic          term_r;
    logic [MW-1:0] mk_r;
    logic          got_r;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r   <= dbs_pkg::CS_IDLE;
            hc_r   <= '0;
            cap_r  <= '0;
            ld_n_r <= 1'b1;
            rw_r   <= 1'b1;
            a_r    <= '0;
            dq_r   <= '0;
            oe_r   <= 1'b1;
            term_r <= 1'b0;
            mk_r   <= '1;
            got_r  <= 1'b0;
            rd0_r  <= '0;
            rd1_r  <= '0;
            fin    <= 1'b0;
        end else begin
            fin <= 1'b0;
            case (st_r)
                dbs_pkg::CS_IDLE: begin
                    if (go_r && mid_low) begin
                        // R6 command shown before true edge
                        ld_n_r <= 1'b0;
                        rw_r   <= rd_r;
                        a_r    <= addr_r;
                        hc_r   <= '0;
                        st_r   <= dbs_pkg::CS_RUN;
                    end
                end
                dbs_pkg::CS_RUN: begin
                    if (mid) begin
                        hc_r <= hc_r + 1'b1;
                        if (hc_r == 3'd0)
                            ld_n_r <= 1'b1;
                        // R7 beat one before next true edge
                        if (hc_r == 3'd1 && !rw_r) begin
                            dq_r <= wd0_r;
                            mk_r <= m0_r;
                        end
                        if (hc_r == 3'd2 && !rw_r) begin
                            dq_r <= wd1_r;
                            mk_r <= m1_r;
                        end
                        if (hc_r == 3'd3 && !rw_r) begin
                            mk_r <= '1;
                            fin  <= 1'b1;
                            st_r <= dbs_pkg::CS_IDLE;
                        end
                        // R16 release and terminate
                        if (hc_r == 3'd1 && rw_r) begin
                            oe_r   <= 1'b0;
                            term_r <= odt_r;
                            cap_r  <= '0;
                            got_r  <= 1'b0;
                            st_r   <= dbs_pkg::CS_CAPT;
                        end
                    end
                end
                dbs_pkg::CS_CAPT: begin
                    // R1 both beats captured mid-beat
                    if (rs2_r[DW] && !qv_d_r && cap_r == '0)
                        cap_r <= (PW+1)'(1);
                    else if (cap_r != '0)
                        cap_r <= cap_r + 1'b1;
                    if (cap_r == (PW+1)'(KH / 2))
                        rd0_r <= rs2_r[DW-1:0];
                    if (cap_r == (PW+1)'(KH + KH / 2)) begin
                        rd1_r <= rs2_r[DW-1:0];
                        cap_r <= '0;
                        got_r <= 1'b1;
                    end
                    // R17 drive again once released
                    if (got_r && !rs2_r[DW]) begin
                        oe_r   <= 1'b1;
                        term_r <= 1'b0;
                        fin    <= 1'b1;
                        st_r   <= dbs_pkg::CS_IDLE;
                    end
                end
                default: st_r <= dbs_pkg::CS_IDLE;
            endcase
        end
    end

    assign link.load_strobe_n      = ld_n_r;
    assign link.read_write_sel     = rw_r;
    assign link.addr               = a_r;
    assign link.dq_ctl             = dq_r;
    assign link.dq_ctl_oe          = oe_r;
    assign link.ctl_term_on        = term_r;
    // R14 masks always driven
    assign link.lane_mask_n        = mk_r;
    assign link.termination_select = odt_r;
endmodule

// >>> sim/dbs_chk.sv
// Link checker: timing relations on the SRAM link wires
`timescale 1ns/1ps
module dbs_chk (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic k,
    input wire logic k_n,
    input wire logic load_strobe_n,
    input wire logic read_write_sel,
    input wire logic termination_select,
    input wire logic dq_ctl_oe,
    input wire logic ctl_term_on,
    input wire logic dq_mem_oe,
    input wire logic mem_term_on,
    input wire logic read_valid_flag
);
    // One domain; reset clears all history
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    flag_oe_a: assert property (read_valid_flag == dq_mem_oe)
        else $error("valid flag apart from drive");
    clk_pair_a: assert property (k_n == !k)
        else $error("link clocks not complementary");
    no_clash_a: assert property (!(dq_mem_oe && dq_ctl_oe))
        else $error("both ends drive data");
    term_read_a: assert property (dq_mem_oe |-> !mem_term_on)
        else $error("termination on while driving");
    // Select low long enough to pass the sync stages
    term_sel_a: assert property (!termination_select [*4] |-> !mem_term_on)
        else $error("termination on while deselected");
    beat_len_a: assert property ($rose(read_valid_flag) |-> ##15 read_valid_flag ##1 !read_valid_flag)
        else $error("read burst not two beats");
    rd_lat_a: assert property ($rose(k) && !load_strobe_n && read_write_sel
        |-> ##[40:46] $rose(read_valid_flag))
        else $error("read data late or missing");
    desel_a: assert property ($rose(k) && load_strobe_n |-> ##46 !dq_mem_oe [*8])
        else $error("driver on after deselect");
    ctl_term_a: assert property (ctl_term_on |-> !dq_ctl_oe && termination_select)
        else $error("controller terminates while driving");
endmodule

// >>> sim/dbs_sram_tb.sv
// Bench: both link ends joined, driven over APB
`timescale 1ns/1ps
module dbs_sram_tb;
    logic        clk_sys_in, resetn_in, psel_in, penable_in, pwrite_in, perr;
    logic        pready_out, pslverr_out;
    logic [7:0]  paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic [5:0]  zref, drive_code_out, term_code_out;
    int          error_cnt = 0, checks_done = 0, cyc = 0;
    // Address, beats, mask, expected beats; row 1 keeps one lane per beat
    logic [31:0] rows [4][6] = '{
        '{32'h05, 32'h2aaaa, 32'h15555, 32'h0, 32'h2aaaa, 32'h15555},
        '{32'h05, 32'h0, 32'h3ffff, 32'h10002, 32'h2aa00, 32'h3ff55},
        '{32'h05, 32'h0, 32'h0, 32'h30003, 32'h2aa00, 32'h3ff55},
        '{32'hff, 32'h3ffff, 32'h1, 32'h0, 32'h3ffff, 32'h1}};
    dbs_link_if link ();
    // Short impedance interval keeps the run brief
    dbs_sram_mem #(.ZQ_EVAL(8)) u_dbs_sram_mem (.clk_sys_in, .resetn_in, .link,
        .impedance_reference_resistor_in(zref), .drive_code_out, .term_code_out);
    dbs_sram_ctl u_dbs_sram_ctl (.clk_sys_in, .resetn_in, .paddr_in, .psel_in, .penable_in,
        .pwrite_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .link);
    dbs_chk u_dbs_chk (.clk_sys_in, .resetn_in, .k(link.k), .k_n(link.k_n),
        .load_strobe_n(link.load_strobe_n), .read_write_sel(link.read_write_sel),
        .termination_select(link.termination_select), .dq_ctl_oe(link.dq_ctl_oe),
        .ctl_term_on(link.ctl_term_on), .dq_mem_oe(link.dq_mem_oe),
        .mem_term_on(link.mem_term_on), .read_valid_flag(link.read_valid_flag));
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the extra edge keeps strobes from doubling up
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        do @(posedge clk_sys_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        perr = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    task automatic op(input logic [31:0] c);
        apb(1'b1, dbs_pkg::OFF_CTRL, c);
        do apb(1'b0, dbs_pkg::OFF_STATUS, 32'h0); while (rd[dbs_pkg::STAT_DONE] !== 1'b1);
    endtask
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    // Hang guard, well above the expected length
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        {resetn_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, zref} = {44'h0, 6'h22};
        repeat (6) @(posedge clk_sys_in);
        chk(32'({link.load_strobe_n, link.lane_mask_n, link.dq_mem_oe, drive_code_out}), 32'h3a0);
        resetn_in <= 1'b1;
        @(posedge clk_sys_in);
        foreach (rows[i]) begin
            apb(1'b1, dbs_pkg::OFF_ADDR, rows[i][0]);
            apb(1'b1, dbs_pkg::OFF_WDATA0, rows[i][1]);
            apb(1'b1, dbs_pkg::OFF_WDATA1, rows[i][2]);
            apb(1'b1, dbs_pkg::OFF_MASK, rows[i][3]);
            op({29'h0, i[0], 2'b01});
            op({29'h0, i[0], 2'b11});
            apb(1'b0, dbs_pkg::OFF_RDATA0, 32'h0);
            chk(rd, rows[i][4]);
            apb(1'b0, dbs_pkg::OFF_RDATA1, 32'h0);
            chk(rd, rows[i][5]);
            $display("row %0d done", i);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk({perr, rd[30:0]}, 32'h80000000);
        chk(32'({drive_code_out, term_code_out}), 32'({6'h22, 6'h22}));
        zref <= 6'h10;
        repeat (20) @(posedge clk_sys_in);
        chk({31'h0, drive_code_out >= 6'h1f}, 32'h1);
        repeat (400) @(posedge clk_sys_in);
        chk(32'({drive_code_out, term_code_out}), 32'({6'h10, 6'h10}));
        $display("impedance test done");
        resetn_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        chk(32'({drive_code_out, term_code_out}), 32'({6'h20, 6'h20}));
        final_report();
    end
endmodule
